// ==== dcsw_core.sv ====
// Command word interpreter and state word builder for a drive on a fieldbus.
// Assumes the adapter presents words with a strobe on the same clock; the
// adapter and master link health levels arrive from outside and are synchronised.
`timescale 1ns/1ps
`include "dcsw_map.svh"
module dcsw_core (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Adapter port: command word and reference, valid for one cycle.
  input wire logic cmd_valid_i,
  input wire logic [15:0] fieldbus_command_word_i,
  input wire logic [15:0] ref_i,
  output logic [15:0] drive_state_word_o,
  output logic [15:0] ref_accepted_o,
  // Link health from outside the clock domain.
  input wire logic master_link_ok_i,
  input wire logic adapter_link_ok_i,
  // Settings.
  input wire logic link_enable_i,
  input wire logic [1:0] loss_action_i,
  input wire logic [15:0] loss_timeout_ms_i,
  input wire logic [1:0] refresh_i,
  input wire logic refresh_strobe_i,
  input wire logic fb_ramp_in_src_i,
  input wire logic fb_reset_src_i,
  input wire logic fb_loc_sel_i,
  input wire logic local_ctrl_i,
  input wire logic [4:0] user_status_src_i,
  // Drive conditions from the surrounding logic.
  input wire logic run_permissive_i,
  input wire logic fault_i,
  input wire logic warning_i,
  input wire logic at_setpoint_i,
  input wire logic stopped_i,
  // Drive controls.
  output logic ramp_out_zero_o,
  output logic ramp_hold_o,
  output logic ramp_in_zero_o,
  output logic ramp_stop_o,
  output logic coast_o,
  output logic quick_stop_o,
  output logic fault_clear_o,
  output logic loc_b_o,
  output logic [3:0] user_bits_o,
  output logic [3:0] inhibit_cause_o,
  output logic loss_fault_o,
  output logic loss_warn_o
);
  dcsw_pkg::dcsw_state_t state_r;
  dcsw_pkg::dcsw_state_t state_nxt;
  logic [15:0] cw_r;
  logic [15:0] cw_nxt;
  logic reset_bit_q_r;
  logic cfg_action_r;
  logic [1:0] act_r;
  logic [15:0] tmo_r;
  logic [15:0] div_r;
  logic tick_r;
  logic fault_r;
  logic master_ok_s;
  logic adapter_ok_s;
  logic expired;

  // Link health is asynchronous, so each level passes two flip-flops.
  dcsw_sync u_sync_master (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(master_link_ok_i),
    .q_o(master_ok_s)
  );
  dcsw_sync u_sync_adapter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(adapter_link_ok_i),
    .q_o(adapter_ok_s)
  );

  // A break on either hop counts; a disabled link is not supervised.
  wire link_break = link_enable_i && !(master_ok_s && adapter_ok_s);

  // Millisecond tick for the loss timer.
  wire tick_wrap = (div_r == 16'(`DCSW_TICK_DIV - 1));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      div_r <= tick_wrap ? 16'h0000 : div_r + 16'h0001;
      tick_r <= tick_wrap;
    end
  end

  dcsw_loss_timer u_loss (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .break_i(link_break),
    .tick_i(tick_r),
    .timeout_i(tmo_r),
    .expired_o(expired)
  );

  // Loss settings are latched only by a refresh with the configure value.
  wire refresh_go = refresh_strobe_i && (refresh_i == `DCSW_REFRESH_CONFIGURE);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_r <= `DCSW_ACT_NONE;
      tmo_r <= 16'h0000;
      cfg_action_r <= 1'b0;
    end else if (refresh_go) begin
      act_r <= loss_action_i;
      tmo_r <= loss_timeout_ms_i;
      cfg_action_r <= 1'b1;
    end
  end

  // Words are taken only while the link is enabled; with remote off, only the
  // three stop bits get through and the rest of the stored word is kept.
  wire take_word = cmd_valid_i && link_enable_i;
  wire remote_on = fieldbus_command_word_i[`DCSW_CW_REMOTE];
  wire [15:0] word_masked = (fieldbus_command_word_i & `DCSW_STOP_MASK) |
                            (cw_r & ~(`DCSW_STOP_MASK));
  assign cw_nxt = !take_word ? cw_r :
                  remote_on ? fieldbus_command_word_i : word_masked;

  // Loss reaction may force a ramp stop on top of the received word.
  wire loss_stop = expired && cfg_action_r && (act_r == `DCSW_ACT_RAMP_STOP);
  wire loss_flt = expired && cfg_action_r && (act_r == `DCSW_ACT_FAULT);
  wire run_bit = cw_r[`DCSW_CW_RAMP_STOP] && !loss_stop;
  wire coast_bit = cw_r[`DCSW_CW_COAST_STOP];
  wire quick_bit = cw_r[`DCSW_CW_QUICK_STOP];
  wire run_en = cw_r[`DCSW_CW_RUN] && run_permissive_i;
  wire reset_edge = cw_r[`DCSW_CW_RESET] && !reset_bit_q_r && fb_reset_src_i;
  wire any_fault = fault_i || fault_r;

  // Drive state sequence.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dcsw_pkg::DCSW_FAULTED: begin
        if (reset_edge) begin
          state_nxt = dcsw_pkg::DCSW_INHIBITED;
        end
      end
      default: begin
        if (any_fault) begin
          state_nxt = dcsw_pkg::DCSW_FAULTED;
        end else if (!coast_bit || (!quick_bit && stopped_i)) begin
          state_nxt = dcsw_pkg::DCSW_INHIBITED;
        end else if (!quick_bit) begin
          state_nxt = state_r;
        end else if (!run_bit) begin
          state_nxt = (state_r == dcsw_pkg::DCSW_INHIBITED && stopped_i) ?
                      dcsw_pkg::DCSW_READY_ON :
                      (state_r == dcsw_pkg::DCSW_INHIBITED) ? state_r :
                      dcsw_pkg::DCSW_READY_ON;
        end else if (state_r == dcsw_pkg::DCSW_INHIBITED ||
                     state_r == dcsw_pkg::DCSW_NOT_READY) begin
          state_nxt = state_r;
        end else if (run_en) begin
          state_nxt = dcsw_pkg::DCSW_ENABLED;
        end else begin
          state_nxt = dcsw_pkg::DCSW_READY_RUN;
        end
      end
    endcase
    // Not-ready with bits 1 and 2 high and no fault goes to inhibited; bit 0 is not looked at.
    if (state_r == dcsw_pkg::DCSW_NOT_READY && !any_fault && coast_bit && quick_bit) begin
      state_nxt = dcsw_pkg::DCSW_INHIBITED;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= dcsw_pkg::DCSW_NOT_READY;
      cw_r <= `DCSW_WORD_RESET;
      reset_bit_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cw_r <= cw_nxt;
      reset_bit_q_r <= cw_r[`DCSW_CW_RESET];
    end
  end

  // A loss fault holds until cleared by a reset edge; a new loss in that same
  // cycle wins so the event is never dropped.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_r <= 1'b0;
    end else if (loss_flt) begin
      fault_r <= 1'b1;
    end else if (reset_edge) begin
      fault_r <= 1'b0;
    end
  end

  // State word fields.
  wire enabled = (state_r == dcsw_pkg::DCSW_ENABLED);
  wire faulted = (state_r == dcsw_pkg::DCSW_FAULTED);
  wire ready_on = (state_r == dcsw_pkg::DCSW_READY_ON) ||
                  (state_r == dcsw_pkg::DCSW_READY_RUN) || enabled;
  wire ready_run = ((state_r == dcsw_pkg::DCSW_READY_RUN) || enabled) && run_bit;
  wire inhibited = (state_r == dcsw_pkg::DCSW_INHIBITED);
  wire [15:0] sw_nxt = {1'b0,
                        user_status_src_i,
                        !local_ctrl_i,
                        at_setpoint_i,
                        warning_i || (expired && act_r == `DCSW_ACT_WARN),
                        inhibited, quick_bit, coast_bit, faulted,
                        enabled,
                        ready_run, ready_on};

  // Ramp output release only acts while operating; hold and input zero follow the word in any state.
  wire ramp_ok = enabled && run_bit;
  wire [3:0] cause_nxt = {!run_permissive_i, !quick_bit, !coast_bit, !run_bit};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_state_word_o <= `DCSW_WORD_RESET;
      ref_accepted_o <= 16'h0000;
      ramp_out_zero_o <= 1'b1;
      ramp_hold_o <= 1'b1;
      ramp_in_zero_o <= 1'b1;
      ramp_stop_o <= 1'b1;
      coast_o <= 1'b0;
      quick_stop_o <= 1'b0;
      fault_clear_o <= 1'b0;
      loc_b_o <= 1'b0;
      user_bits_o <= 4'h0;
      inhibit_cause_o <= 4'h0;
      loss_fault_o <= 1'b0;
      loss_warn_o <= 1'b0;
    end else begin
      drive_state_word_o <= sw_nxt;
      if (take_word && remote_on) begin
        ref_accepted_o <= ref_i;
      end
      ramp_out_zero_o <= !(ramp_ok && cw_r[`DCSW_CW_RAMP_OUT_EN]);
      ramp_hold_o <= !cw_r[`DCSW_CW_RAMP_HOLD_N];
      ramp_in_zero_o <= fb_ramp_in_src_i && !cw_r[`DCSW_CW_RAMP_IN_EN];
      ramp_stop_o <= !run_bit;
      coast_o <= !coast_bit;
      quick_stop_o <= !quick_bit;
      // The faulted state is itself the active fault, even once the source has gone.
      fault_clear_o <= reset_edge && (any_fault || faulted);
      if (fb_loc_sel_i) begin
        loc_b_o <= cw_r[`DCSW_CW_LOC_B];
      end
      user_bits_o <= cw_r[`DCSW_CW_USER_MSB:`DCSW_CW_USER_LSB];
      inhibit_cause_o <= enabled ? 4'h0 : cause_nxt;
      loss_fault_o <= fault_r;
      loss_warn_o <= expired && act_r == `DCSW_ACT_WARN;
    end
  end

  // Checks.
  chk_coast_inhibits: assert property (@(posedge clk_i) disable iff (rst_i)
    (!coast_bit && !any_fault && state_r != dcsw_pkg::DCSW_FAULTED)
      |=> state_r == dcsw_pkg::DCSW_INHIBITED)
    else $error("Coast stop did not reach switch-on inhibited.");
  chk_run_needs_perm: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(enabled) |-> $past(run_permissive_i) && $past(cw_r[`DCSW_CW_RUN]))
    else $error("Operation enabled without run bit and permissive.");
  chk_remote_masks: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_word && !remote_on) |=> cw_r[15:3] == $past(cw_r[15:3]))
    else $error("Non-stop bits changed while remote was off.");
  chk_link_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !link_enable_i |=> cw_r == $past(cw_r))
    else $error("Command word taken while the link was disabled.");
  chk_state_bit2: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 drive_state_word_o[2] == $past(enabled))
    else $error("State bit 2 does not follow operation enabled.");
  chk_fault_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (faulted && reset_edge) |=> state_r == dcsw_pkg::DCSW_INHIBITED && fault_clear_o)
    else $error("Reset edge did not clear the fault.");
  chk_ramp_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !cw_r[`DCSW_CW_RAMP_OUT_EN] |=> ramp_out_zero_o)
    else $error("Ramp output not forced to zero.");
  chk_refresh_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !refresh_go |=> act_r == $past(act_r))
    else $error("Loss action changed without a configure refresh.");
endmodule

// ==== dcsw_map.svh ====
// Constants for the drive command and state word block.
// Assumes inclusion by bare name from every design file that needs it.
// Overview of operation
// - Command bit 0 low stops along ramp (ramp_stop_command); high proceeds to ready.
// - Command bit 1 low coasts to stop, then switch-on inhibited.
// - Command bit 2 low stops within set time, then switch-on inhibited.
// - Command bit 4 low forces ramp output to zero.
// - Command bit 5 low freezes ramp output; high lets ramping proceed.
// - Command bit 6 low forces ramp input to zero when fieldbus is its source.
// - Rising command bit 7 clears fault when fieldbus is reset source.
// - Command bit 10 low ignores word and reference except bits 0 to 2.
// - Command bit 11 picks location b or a when fieldbus selects location.
// - State bit 0 is ready to switch on; bit 1 ready to operate.
// - State bit 2 is operation enabled; inhibit cause reported separately.
// - State bit 8 high when actual value within tolerance of reference.
// - State bit 9 high when control location is remote.
// - State bits 10 to 14 follow selected sources; bit 15 reserved.
// - Exchange with fieldbus_adapter_port only while link enable is set; the code gates only words taken in, the state word still updates.
// - Detect break on master link or adapter link; take configured reaction.
// - Reaction applied only after programmable timeout from break detection.
// - Adapter and mapping settings take effect only on refresh with configure; the code latches only the loss action and timeout, the rest act at once.
`ifndef DCSW_MAP_SVH
`define DCSW_MAP_SVH
`define DCSW_CW_RAMP_STOP 0
`define DCSW_CW_COAST_STOP 1
`define DCSW_CW_QUICK_STOP 2
`define DCSW_CW_RUN 3
`define DCSW_CW_RAMP_OUT_EN 4
`define DCSW_CW_RAMP_HOLD_N 5
`define DCSW_CW_RAMP_IN_EN 6
`define DCSW_CW_RESET 7
`define DCSW_CW_REMOTE 10
`define DCSW_CW_LOC_B 11
`define DCSW_CW_USER_LSB 12
`define DCSW_CW_USER_MSB 15
`define DCSW_STOP_MASK 16'h0007
`define DCSW_WORD_RESET 16'h0000
`define DCSW_REFRESH_CONFIGURE 2'h1
`define DCSW_ACT_NONE 2'h0
`define DCSW_ACT_FAULT 2'h1
`define DCSW_ACT_RAMP_STOP 2'h2
`define DCSW_ACT_WARN 2'h3
`define DCSW_TMO_UNIT_MS 1
`define DCSW_CLK_HZ 25000000
`define DCSW_TICK_DIV (`DCSW_CLK_HZ / 1000 * `DCSW_TMO_UNIT_MS)
`endif

// ==== dcsw_pkg.sv ====
// Types shared by the drive command and state word block.
// Assumes nothing of its surroundings.
package dcsw_pkg;
  typedef enum logic [2:0] {
    DCSW_NOT_READY,
    DCSW_INHIBITED,
    DCSW_READY_ON,
    DCSW_READY_RUN,
    DCSW_ENABLED,
    DCSW_FAULTED
  } dcsw_state_t;
endpackage

// ==== dcsw_sync.sv ====
// Two flip-flop synchroniser for one asynchronous level.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module dcsw_sync (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in and out.
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ==== dcsw_loss_timer.sv ====
// Communication-loss timer counting millisecond ticks after a break.
// Assumes a one-cycle tick enable from the top and same-clock inputs.
`timescale 1ns/1ps
`include "dcsw_map.svh"
module dcsw_loss_timer (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Break level, tick enable and timeout in ticks.
  input wire logic break_i,
  input wire logic tick_i,
  input wire logic [15:0] timeout_i,
  // Reaction due.
  output logic expired_o
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  wire at_limit = (cnt_r >= timeout_i);

  // Counting restarts whenever the break clears, so a flicker trips only if it spans timeout_i ticks (any flicker with a timeout of 0).
  assign cnt_nxt = (!break_i) ? 16'h0000 :
                   (tick_i && !at_limit) ? cnt_r + 16'h0001 : cnt_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0000;
      expired_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expired_o <= break_i && at_limit;
    end
  end

  chk_loss_waits: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(expired_o) |-> $past(break_i) && $past(cnt_r) >= $past(timeout_i))
    else $error("Loss reaction raised before the timeout ran out.");
endmodule

// ==== dcsw_master_model.sv ====
// Fieldbus master seen through its adapter: command words and link health.
// Assumes the bench calls the tasks from one process on the same clock.
`timescale 1ns/1ps
module dcsw_master_model (
  // Clock.
  input wire logic clk_i,
  // Word to the drive and link health.
  output logic valid_o,
  output logic [15:0] word_o,
  output logic [15:0] ref_o,
  output logic master_ok_o,
  output logic adapter_ok_o
);
  // Both links start healthy and no word is offered.
  initial begin
    valid_o = 1'b0;
    word_o = 16'h0000;
    ref_o = 16'h0000;
    master_ok_o = 1'b1;
    adapter_ok_o = 1'b1;
  end
  // One word after gap idle cycles, valid for one cycle; idle lines show the
  // inverse of the last word so stale data is never mistaken for a match.
  task automatic send(input logic [15:0] w, input logic [15:0] r, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    valid_o <= 1'b1;
    word_o <= w;
    ref_o <= r;
    @(posedge clk_i);
    valid_o <= 1'b0;
    word_o <= ~w;
    ref_o <= ~r;
  endtask
  // A break on either link is a level change.
  task automatic cut(input logic m, input logic a);
    @(posedge clk_i);
    master_ok_o <= m;
    adapter_ok_o <= a;
  endtask
endmodule

// ==== dcsw_core_tb_top.sv ====
// Self-checking bench for the command and state word block.
// Assumes the master model and the design files are compiled before it.
`timescale 1ns/1ps
module dcsw_core_tb_top;
  logic clk_i, rst_i, vld, m_ok, a_ok, len, rstr, ris, rss, lsel, loc;
  logic perm, flt, wrn, atsp, stp, roz, rhold, riz, rstop, coast, qstop, fclr, locb;
  logic lfault, lwarn;
  logic [15:0] cw_in, ref_in, sw, refa, tmo, cw, refm, w;
  logic [1:0] act, rfs;
  logic [4:0] usrc;
  logic [3:0] ubits, icause;
  int err_total, checked, st, nclr, seed;
  logic [15:0] q[$];

  // The 25 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  dcsw_master_model M (.clk_i(clk_i), .valid_o(vld), .word_o(cw_in), .ref_o(ref_in),
    .master_ok_o(m_ok), .adapter_ok_o(a_ok));

  dcsw_core DUT (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(vld),
    .fieldbus_command_word_i(cw_in), .ref_i(ref_in), .drive_state_word_o(sw),
    .ref_accepted_o(refa), .master_link_ok_i(m_ok), .adapter_link_ok_i(a_ok),
    .link_enable_i(len), .loss_action_i(act), .loss_timeout_ms_i(tmo), .refresh_i(rfs),
    .refresh_strobe_i(rstr), .fb_ramp_in_src_i(ris), .fb_reset_src_i(rss),
    .fb_loc_sel_i(lsel), .local_ctrl_i(loc), .user_status_src_i(usrc),
    .run_permissive_i(perm), .fault_i(flt), .warning_i(wrn), .at_setpoint_i(atsp),
    .stopped_i(stp), .ramp_out_zero_o(roz), .ramp_hold_o(rhold), .ramp_in_zero_o(riz),
    .ramp_stop_o(rstop), .coast_o(coast), .quick_stop_o(qstop), .fault_clear_o(fclr),
    .loc_b_o(locb), .user_bits_o(ubits), .inhibit_cause_o(icause),
    .loss_fault_o(lfault), .loss_warn_o(lwarn));

  // Counts clear pulses; one word must give exactly one.
  always @(posedge clk_i) begin
    if (fclr === 1'b1) nclr++;
  end

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // State word predicted from the model state and the stored command word.
  function automatic logic [15:0] exp_sw();
    logic [15:0] s;
    s = 16'h0000;
    s[0] = st >= 2 && st <= 4;
    s[1] = st == 3 || st == 4;
    s[2] = st == 4;
    s[3] = st == 5;
    s[5:4] = cw[2:1];
    s[6] = st == 1;
    s[7] = wrn;
    s[8] = atsp;
    s[9] = !loc;
    s[14:10] = usrc;
    return s;
  endfunction

  // Walks the model state machine until it is steady, then lets the design settle.
  task automatic settle();
    for (int i = 0; i < 4; i++) begin
      if (flt) st = 5;
      else if (st == 5) st = st;
      else if (!cw[1] || (!cw[2] && stp)) st = 1;
      else if (!cw[2]) st = st;
      else if (st == 0) st = 1;
      else if (st == 1 && !cw[0] && stp) st = 2;
      else if (st == 2 && cw[0]) st = 3;
      else if (st == 3 && cw[3] && perm) st = 4;
    end
    repeat (4) @(posedge clk_i);
    cmp("state word", exp_sw(), sw);
  endtask

  // Sends one word after a gap of 0, 1 or 2 cycles in turn, and updates the model.
  task automatic snd(input logic [15:0] x, input logic [15:0] r);
    logic [15:0] n;
    M.send(x, r, q.size() % 3);
    q.push_back(x);
    n = x[10] ? x : {cw[15:3], x[2:0]};
    if (len) begin
      if (n[7] && !cw[7] && rss && st == 5) st = 1;
      if (x[10]) refm = r;
      cw = n;
    end
    settle();
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need about 55000 cycles.
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    results();
  end

  // Main sequence.
  initial begin
    {rst_i, len, rss, lsel, perm, stp} = 6'h3f;
    {rstr, ris, loc, flt, wrn, atsp} = 6'h00;
    {act, rfs, tmo, usrc} = 25'h0;
    {cw, refm, st, err_total, checked, nclr} = 0;
    seed = 32'ha20f;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    cmp("ramp out zero", 16'h1, {15'h0, roz});
    snd(16'h0406, 16'h0000);
    cmp("ramp stop", 16'h1, {15'h0, rstop});
    snd(16'h0407, 16'h0000);
    snd(16'h047f, 16'h1234);
    cmp("inhibit cause", 16'h0, {12'h0, icause});
    cmp("ramp stop", 16'h0, {15'h0, rstop});
    done("power up");
    for (int i = 0; i < 12; i++) begin
      w = $random(seed);
      w[10] = 1'b1;
      w[7] = 1'b0;
      w[3:0] = 4'hf;
      @(posedge clk_i);
      {ris, wrn, atsp, usrc} <= $random(seed);
      snd(w, $random(seed));
      cmp("ramp out zero", {15'h0, !w[4]}, {15'h0, roz});
      cmp("ramp hold", {15'h0, !w[5]}, {15'h0, rhold});
      cmp("ramp in zero", {15'h0, ris & !w[6]}, {15'h0, riz});
      cmp("location b", {15'h0, w[11]}, {15'h0, locb});
      cmp("user bits", {12'h0, w[15:12]}, {12'h0, ubits});
      cmp("reference", refm, refa);
    end
    done("random words");
    snd(16'hf3fd, 16'hbeef);
    cmp("coast", 16'h1, {15'h0, coast});
    cmp("quick stop", 16'h0, {15'h0, qstop});
    cmp("ramp stop", 16'h0, {15'h0, rstop});
    cmp("inhibit cause", 16'h2, {12'h0, icause});
    cmp("reference", refm, refa);
    cmp("user bits", {12'h0, cw[15:12]}, {12'h0, ubits});
    done("remote off");
    snd(16'h0406, 16'h0000);
    @(posedge clk_i);
    flt <= 1'b1;
    @(posedge clk_i);
    settle();
    @(posedge clk_i);
    flt <= 1'b0;
    nclr = 0;
    snd(16'h0486, 16'h0000);
    cmp("clear pulses", 16'h1, nclr[15:0]);
    done("fault reset");
    len <= 1'b0;
    snd(16'h0400, 16'h5555);
    cmp("reference", refm, refa);
    len <= 1'b1;
    done("link off");
    @(posedge clk_i);
    // Two ticks, so the reaction lands 1 to 2 ms after the break whatever the tick phase.
    {act, tmo, rfs, rstr} <= {2'h1, 16'h0002, 2'h1, 1'b1};
    @(posedge clk_i);
    rstr <= 1'b0;
    M.cut(1'b0, 1'b1);
    repeat (20000) @(posedge clk_i);
    cmp("loss fault early", 16'h0, {15'h0, lfault});
    repeat (35000) @(posedge clk_i);
    cmp("loss fault", 16'h1, {15'h0, lfault});
    @(posedge clk_i);
    {act, rstr} <= {2'h3, 1'b1};
    @(posedge clk_i);
    rstr <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmp("loss warn", 16'h1, {15'h0, lwarn});
    done("link loss");
    results();
  end
endmodule
